/* design/charge_if.sv */
// Frame charge request and result between the register bank and the charge unit
interface charge_if;
  logic req_valid;
  ingress_rate_pkg::frame_len_t req_len;
  logic req_bcast;
  logic req_mcast;
  logic req_flood;
  logic req_own;
  ingress_rate_pkg::rate_code_t req_code;
  ingress_rate_pkg::limit_mode_t limit_mode;
  logic gap_bytes_accounted;
  logic preamble_accounted;
  logic res_valid;
  ingress_rate_pkg::charge_bytes_t res_bytes;
  logic res_limited;
  ingress_rate_pkg::rate_code_t res_code;

  modport bank (
    output req_valid, req_len, req_bcast, req_mcast, req_flood, req_own, req_code,
    output limit_mode, gap_bytes_accounted, preamble_accounted,
    input res_valid, res_bytes, res_limited, res_code
  );
  modport unit (
    input req_valid, req_len, req_bcast, req_mcast, req_flood, req_own, req_code,
    input limit_mode, gap_bytes_accounted, preamble_accounted,
    output res_valid, res_bytes, res_limited, res_code
  );
endinterface

/* design/frame_charge.sv */
// Per-frame byte charge and limit decision for the ingress rate limiter
`include "ingress_rate_regs.svh"

module frame_charge (
  input wire logic i_clk,
  input wire logic i_rst_b,
  charge_if.unit chg
);

  // ****************************************
  // Frame class filter and byte charge
  // ****************************************
  logic class_match;
  ingress_rate_pkg::charge_bytes_t gap_add;
  ingress_rate_pkg::charge_bytes_t pre_add;
  ingress_rate_pkg::charge_bytes_t next_bytes;

  assign class_match = (chg.limit_mode == `MODE_ALL) ? 1'b1 :
                       (chg.limit_mode == `MODE_BC_MC_FLOOD) ? (chg.req_bcast | chg.req_mcast | chg.req_flood) :
                       (chg.limit_mode == `MODE_BC_MC) ? (chg.req_bcast | chg.req_mcast) :
                       chg.req_bcast;
  assign gap_add = chg.gap_bytes_accounted ? `GAP_BYTES : 12'h000;
  assign pre_add = chg.preamble_accounted ? `PREAMBLE_BYTES : 12'h000;
  assign next_bytes = {1'b0, chg.req_len} + gap_add + pre_add;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      chg.res_valid <= 1'b0;
      chg.res_bytes <= 12'h000;
      chg.res_limited <= 1'b0;
      chg.res_code <= `RATE_CODE_RESET;
    end else begin
      chg.res_valid <= chg.req_valid;
      if (chg.req_valid) begin
        chg.res_bytes <= next_bytes;
        chg.res_limited <= class_match & chg.req_own;
        chg.res_code <= chg.req_code;
      end
    end
  end

endmodule

/* design/ingress_rate_bank.sv */
// Ingress rate code registers for priorities 1 to 3 on four ports
`include "ingress_rate_regs.svh"

module ingress_rate_bank (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic o_reg_rvalid,
  output logic [7:0] o_reg_rdata,
  input wire logic [1:0] i_limit_mode,
  input wire logic i_gap_bytes_accounted,
  input wire logic i_preamble_accounted,
  input wire logic i_frm_valid,
  input wire logic [1:0] i_frm_port,
  input wire logic [1:0] i_frm_prio,
  input wire logic [10:0] i_frm_len,
  input wire logic i_frm_bcast,
  input wire logic i_frm_mcast,
  input wire logic i_frm_flood,
  output logic [3:0][2:0][6:0] o_rate_code,
  output logic o_chg_valid,
  output logic [11:0] o_chg_bytes,
  output logic o_chg_limited,
  output logic [6:0] o_chg_code
);

  // ****************************************
  // Address decode
  // ****************************************
  // Port n block starts at 0xC8 + n * 0x10; high nibble C..F picks the port.
  logic [7:0] addr_rel;
  logic [1:0] dec_port;
  logic [3:0] dec_slot;
  logic dec_hit;
  logic [1:0] dec_prio;

  assign addr_rel = i_reg_addr - `PORT1_PRIO1_INGRESS_RATE;
  assign dec_port = addr_rel[5:4];
  assign dec_slot = addr_rel[3:0];
  assign dec_hit = (i_reg_addr >= `PORT1_PRIO1_INGRESS_RATE) && (dec_slot < 4'h3);
  assign dec_prio = dec_slot[1:0];

  // ****************************************
  // Rate code storage
  // ****************************************
  ingress_rate_pkg::rate_code_t code [4][3];

  for (genvar p = 0; p < 4; p++) begin : g_port
    for (genvar q = 0; q < 3; q++) begin : g_prio
      logic wr_sel;
      assign wr_sel = i_reg_wr && dec_hit && (dec_port == 2'(p)) && (dec_prio == 2'(q));
      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          code[p][q] <= `RATE_CODE_RESET;
        end else if (wr_sel) begin
          // Bit 7 is dropped so the reserved bit can never be set
          code[p][q] <= i_reg_wdata[`RATE_CODE_MSB:0];
        end
      end
      assign o_rate_code[p][q] = code[p][q];
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  logic [7:0] rd_value;

  assign rd_value = dec_hit ? {1'b0, code[dec_port][dec_prio]} : `UNMAPPED_READ;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_reg_rvalid <= 1'b0;
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rd_value;
      end
    end
  end

  // ****************************************
  // Frame charge path
  // ****************************************
  // Priority 0 codes live elsewhere, so such frames pass through unlimited here.
  charge_if chg ();
  logic frm_own;
  logic [1:0] frm_idx;

  assign frm_own = (i_frm_prio != 2'h0);
  assign frm_idx = frm_own ? (i_frm_prio - 2'h1) : 2'h0;

  assign chg.req_valid = i_frm_valid;
  assign chg.req_len = i_frm_len;
  assign chg.req_bcast = i_frm_bcast;
  assign chg.req_mcast = i_frm_mcast;
  assign chg.req_flood = i_frm_flood;
  assign chg.req_own = frm_own;
  assign chg.req_code = frm_own ? code[i_frm_port][frm_idx] : `RATE_CODE_RESET;
  assign chg.limit_mode = i_limit_mode;
  assign chg.gap_bytes_accounted = i_gap_bytes_accounted;
  assign chg.preamble_accounted = i_preamble_accounted;

  frame_charge frame_charge_inst (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .chg(chg.unit)
  );

  assign o_chg_valid = chg.res_valid;
  assign o_chg_bytes = chg.res_bytes;
  assign o_chg_limited = chg.res_limited;
  assign o_chg_code = chg.res_code;

endmodule

/* design/ingress_rate_pkg.sv */
// Types shared by the ingress rate register bank and its frame charge unit
package ingress_rate_pkg;
  typedef logic [6:0] rate_code_t;
  typedef logic [1:0] limit_mode_t;
  typedef logic [10:0] frame_len_t;
  typedef logic [11:0] charge_bytes_t;
endpackage

/* design/ingress_rate_regs.svh */
// Offsets, field positions, reset values and byte counts of the ingress rate bank
`ifndef INGRESS_RATE_REGS_SVH
`define INGRESS_RATE_REGS_SVH

`define PORT1_PRIO1_INGRESS_RATE 8'hC8
`define PORT1_PRIO2_INGRESS_RATE 8'hC9
`define PORT1_PRIO3_INGRESS_RATE 8'hCA
`define PORT2_PRIO1_INGRESS_RATE 8'hD8
`define PORT2_PRIO2_INGRESS_RATE 8'hD9
`define PORT2_PRIO3_INGRESS_RATE 8'hDA
`define PORT3_PRIO1_INGRESS_RATE 8'hE8
`define PORT3_PRIO2_INGRESS_RATE 8'hE9
`define PORT3_PRIO3_INGRESS_RATE 8'hEA
`define PORT4_PRIO1_INGRESS_RATE 8'hF8
`define PORT4_PRIO2_INGRESS_RATE 8'hF9
`define PORT4_PRIO3_INGRESS_RATE 8'hFA

`define RATE_PORT_STRIDE 8'h10
`define RATE_CODE_MSB 6
`define RATE_CODE_RESET 7'h00
`define RATE_RSVD_BIT 7
`define UNMAPPED_READ 8'h00

`define MODE_ALL 2'h0
`define MODE_BC_MC_FLOOD 2'h1
`define MODE_BC_MC 2'h2
`define MODE_BC_ONLY 2'h3

`define GAP_BYTES 12'h00C
`define PREAMBLE_BYTES 12'h008

`endif

/* verif/ingress_rate_bank_props.sv */
// Port checks for the ingress rate bank
module ingress_rate_bank_props (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic o_reg_rvalid,
  input wire logic [7:0] o_reg_rdata,
  input wire logic [1:0] i_limit_mode,
  input wire logic i_gap_bytes_accounted,
  input wire logic i_preamble_accounted,
  input wire logic i_frm_valid,
  input wire logic i_frm_bcast,
  input wire logic [1:0] i_frm_prio,
  input wire logic [10:0] i_frm_len,
  input wire logic [3:0][2:0][6:0] o_rate_code,
  input wire logic o_chg_valid,
  input wire logic [11:0] o_chg_bytes,
  input wire logic o_chg_limited,
  input wire logic [6:0] o_chg_code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_rd_ans; o_reg_rvalid && !o_reg_rdata[7]; endsequence
  property p_rd; i_reg_rd |=> s_rd_ans; endproperty
  a_rd: assert property (p_rd) else $error("bad read answer");
  property p_wr;
    i_reg_wr && i_reg_addr == 8'hF9 |=> {1'b0, o_rate_code[3][1]} == ($past(i_reg_wdata) & 8'h7F);
  endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_hold; !i_reg_wr |=> $stable(o_rate_code); endproperty
  a_hold: assert property (p_hold) else $error("code moved");
  property p_chg; i_frm_valid |=> o_chg_valid; endproperty
  a_chg: assert property (p_chg) else $error("no charge");
  property p_gap;
    i_frm_valid && i_gap_bytes_accounted && !i_preamble_accounted |=> o_chg_bytes == $past(i_frm_len) + 12'h00C;
  endproperty
  a_gap: assert property (p_gap) else $error("gap bytes");
  property p_pre;
    i_frm_valid && !i_gap_bytes_accounted && i_preamble_accounted |=> o_chg_bytes == $past(i_frm_len) + 12'h008;
  endproperty
  a_pre: assert property (p_pre) else $error("preamble bytes");
  property p_mode; i_frm_valid && i_limit_mode == 2'h0 && i_frm_prio != 2'h0 |=> o_chg_limited; endproperty
  a_mode: assert property (p_mode) else $error("mode all");
  property p_p0; i_frm_valid && i_frm_prio == 2'h0 |=> !o_chg_limited && o_chg_code == 7'h00; endproperty
  a_p0: assert property (p_p0) else $error("prio 0");
  property p_rd_idle; !i_reg_rd |=> !o_reg_rvalid; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read answer held");
  property p_chg_idle; !i_frm_valid |=> !o_chg_valid; endproperty
  a_chg_idle: assert property (p_chg_idle) else $error("charge held");
  property p_bc_only;
    i_frm_valid && i_limit_mode == 2'h3 && i_frm_prio != 2'h0 |=> o_chg_limited == $past(i_frm_bcast);
  endproperty
  a_bc_only: assert property (p_bc_only) else $error("broadcast only mode");
endmodule
bind ingress_rate_bank ingress_rate_bank_props ingress_rate_bank_props_inst (.*);

/* verif/ingress_rate_bank_tb_top.sv */
// Self-checking bench for the ingress rate bank
module ingress_rate_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst_b, i_reg_wr, i_reg_rd, i_frm_valid, i_frm_bcast, i_frm_mcast, i_frm_flood;
  logic i_gap_bytes_accounted, i_preamble_accounted, o_reg_rvalid, o_chg_valid, o_chg_limited;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic [1:0] i_limit_mode, i_frm_port, i_frm_prio;
  logic [10:0] i_frm_len;
  logic [3:0][2:0][6:0] o_rate_code;
  logic [11:0] o_chg_bytes;
  logic [6:0] o_chg_code;
  int bad_count = 0, total_checks = 0;
  ingress_rate_bank ingress_rate_bank_inst (.*);
  initial begin
    i_clk = 0;
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [11:0] d);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1;
    d = o_reg_rvalid ? {4'h0, o_reg_rdata} : 12'hFFF;
  endtask
  task automatic frm(input logic [1:0] p, q, c, m);
    @(posedge i_clk);
    i_frm_valid <= 1'b1;
    i_frm_port <= p;
    i_frm_prio <= q;
    i_frm_len <= 11'h040 + 11'(c);
    i_frm_flood <= c == 2'h1;
    i_frm_mcast <= c == 2'h2;
    i_frm_bcast <= c == 2'h3;
    i_limit_mode <= m;
    i_gap_bytes_accounted <= m[0];
    i_preamble_accounted <= m[1];
    @(posedge i_clk);
    i_frm_valid <= 1'b0;
    #1;
  endtask
  function automatic logic [7:0] adr(input int i);
    return 8'hC8 + 8'(i / 3 * 16 + i % 3);
  endfunction
  initial begin
    #100000;
    bad_count++;
    test_done();
  end
  initial begin
    logic [11:0] d;
    logic [6:0] code [12];
    {i_rst_b, i_reg_wr, i_reg_rd, i_frm_valid, i_frm_bcast, i_frm_mcast, i_frm_flood} = '0;
    {i_gap_bytes_accounted, i_preamble_accounted, i_reg_addr, i_reg_wdata, i_limit_mode} = '0;
    {i_frm_port, i_frm_prio, i_frm_len} = '0;
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      rd(adr(i), d);
      chk(d, 12'h000);
      code[i] = 7'(i * 9 + 5);
      wr(adr(i), {1'b1, code[i]});
    end
    for (int i = 0; i < 12; i++) begin
      rd(adr(i), d);
      chk(d, {5'h00, code[i]});
      chk({5'h00, o_rate_code[i / 3][i % 3]}, {5'h00, code[i]});
    end
    // Unmapped places swallow writes
    wr(8'hCB, 8'h55);
    rd(8'hCB, d);
    chk(d, 12'h000);
    chk({5'h00, o_rate_code[0][2]}, {5'h00, code[2]});
    // Below the bank the low nibble alone would alias onto port 4
    wr(8'hB8, 8'h2A);
    rd(8'hB8, d);
    chk(d, 12'h000);
    chk({5'h00, o_rate_code[3][0]}, {5'h00, code[9]});
    $display("register tests done");
    for (int m = 0; m < 4; m++)
      for (int c = 0; c < 4; c++) begin
        frm(2'(c), 2'((m + c) % 3 + 1), 2'(c), 2'(m));
        chk({11'h000, o_chg_valid}, 12'h001);
        chk(o_chg_bytes, 12'(64 + c + 12 * (m % 2) + 8 * (m / 2)));
        chk({11'h000, o_chg_limited}, {11'h000, c >= m});
        chk({5'h00, o_chg_code}, {5'h00, code[c * 3 + (m + c) % 3]});
      end
    frm(2'h1, 2'h0, 2'h3, 2'h0);
    chk({4'h0, o_chg_limited, o_chg_code}, 12'h000);
    $display("charge tests done");
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    #1;
    chk({11'h000, o_rate_code != '0}, 12'h000);
    chk({3'h0, o_chg_valid, o_chg_limited, o_chg_code}, 12'h000);
    chk(o_chg_bytes, 12'h000);
    rd(adr(7), d);
    chk(d, 12'h000);
    $display("reset tests done");
    test_done();
  end
endmodule
